// >>> rtl/cexu_pkg.sv
package cexu_pkg;

  // --------------------------------------------------------------------
  // Register map, byte offsets on the APB
  // --------------------------------------------------------------------
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] FRAME0_OFS = 8'h08;
  localparam logic [7:0] FRAME1_OFS = 8'h0c;
  localparam logic [7:0] SSP_OFS = 8'h10;
  localparam logic [7:0] SR_OFS = 8'h14;

  // Configuration bit positions
  localparam int CFG_ARD_BIT = 0;
  localparam int CFG_IRD_BIT = 1;
  localparam int CFG_STOP_BIT = 2;
  localparam int CFG_WAIT_BIT = 3;
  localparam int CFG_BDM_BIT = 4;
  localparam logic [4:0] CFG_RST = 5'h00;

  // --------------------------------------------------------------------
  // Fault status codes and vectors
  // --------------------------------------------------------------------
  localparam logic [3:0] FS_NONE = 4'h0;
  localparam logic [3:0] FS_FETCH = 4'h4;
  localparam logic [3:0] FS_WRITE = 4'h8;
  localparam logic [3:0] FS_WPROT = 4'h9;
  localparam logic [3:0] FS_READ = 4'hc;
  localparam logic [7:0] VEC_ACCESS = 8'h02;
  localparam logic [7:0] VEC_ADDR = 8'h03;
  localparam logic [7:0] VEC_ILLEGAL = 8'h04;
  localparam logic [7:0] VEC_LINE_A = 8'h0a;
  localparam logic [7:0] VEC_LINE_F = 8'h0b;
  localparam logic [3:0] FMT_BASE = 4'h4;
  localparam logic [2:0] LEVEL_NMI = 3'h7;
  localparam logic [15:0] OP_ILLEGAL = 16'h4afc;
  localparam logic [3:0] LINE_A = 4'ha;
  localparam logic [3:0] LINE_F = 4'hf;
  localparam int EXT_FULL_BIT = 8;
  localparam int EXT_SIZE_BIT = 11;
  localparam logic [1:0] SCALE_EIGHT = 2'h3;
  localparam logic [31:0] FRAME_BYTES = 32'h0000_0008;
  localparam logic [15:0] SR_RST = 16'h2700;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    CEXU_ACC_FETCH,
    CEXU_ACC_READ,
    CEXU_ACC_WRITE,
    CEXU_ACC_WPROT
  } cexu_acc_e;

  typedef struct packed
  {
    logic valid;
    logic [15:0] opword;
    logic [15:0] ext1;
    logic has_ext;
    logic indexed;
    logic [31:0] pc;
    logic [31:0] next_pc;
    logic opword_faulted;
    logic ext_faulted;
    logic is_nop;
    logic is_stop;
    logic is_halt;
    logic is_rts;
    logic illegal;
  } cexu_instr_s;

  typedef struct packed
  {
    logic [3:0] fmt;
    logic [3:0] fs;
    logic [7:0] vector;
    logic [15:0] sr;
    logic [31:0] pc;
  } cexu_frame_s;

endpackage

// >>> rtl/cexu_core_exception_unit.sv
`timescale 1ns/100ps
module cexu_core_exception_unit
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Instruction presented for execution
  input wire cexu_pkg::cexu_instr_s instr_in,
  input wire logic flow_change_in,
  input wire logic target_valid_in,
  input wire logic [31:0] target_addr_in,
  // Bus errors from the fabric
  input wire logic acc_err_in,
  input wire cexu_pkg::cexu_acc_e acc_kind_in,
  input wire logic writes_pending_in,
  // Interrupt controller
  input wire logic [2:0] irq_level_in,
  input wire logic [7:0] irq_vector_in,
  input wire logic handler_first_done_in,
  // Results
  output logic stall_out,
  output logic exc_take_out,
  output logic reset_req_out,
  output logic abort_out,
  output cexu_pkg::cexu_frame_s frame_out,
  output logic [31:0] frame_addr_out,
  output logic irq_ack_out
);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [4:0] cfg_ff;
  logic [31:0] ssp_ff;
  logic [15:0] sr_ff;
  logic fetch_err_ff;
  logic write_err_ff;
  logic sampling_off_ff;
  logic nmi_seen_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic stall_ff;
  logic exc_take_ff;
  logic reset_req_ff;
  logic abort_ff;
  cexu_pkg::cexu_frame_s frame_ff;
  logic [31:0] frame_addr_ff;
  logic irq_ack_ff;

  // Event chosen this cycle
  logic ev;
  logic ev_reset;
  logic ev_irq;
  logic [3:0] ev_fs;
  logic [7:0] ev_vec;
  logic [31:0] ev_pc;
  logic [31:0] ev_sp;

  // --------------------------------------------------------------------
  // Opword decode
  // --------------------------------------------------------------------
  function automatic logic [3:0] op_line(input logic [15:0] op);
    op_line = op[15:12];
  endfunction

  function automatic logic bad_index(input logic [15:0] ext);
    // Word index, scale of eight or full format are not supported
    bad_index = !ext[cexu_pkg::EXT_SIZE_BIT] ||
                (ext[10:9] == cexu_pkg::SCALE_EIGHT) ||
                ext[cexu_pkg::EXT_FULL_BIT];
  endfunction

  wire logic acc_wr = acc_err_in &&
    (acc_kind_in == cexu_pkg::CEXU_ACC_WRITE ||
     acc_kind_in == cexu_pkg::CEXU_ACC_WPROT);
  wire logic acc_rd = acc_err_in && acc_kind_in == cexu_pkg::CEXU_ACC_READ;
  wire logic acc_fe = acc_err_in && acc_kind_in == cexu_pkg::CEXU_ACC_FETCH;
  wire logic [3:0] line = op_line(instr_in.opword);
  wire logic lowpwr_off = !cfg_ff[cexu_pkg::CFG_STOP_BIT] &&
                          !cfg_ff[cexu_pkg::CFG_WAIT_BIT];
  wire logic is_illegal_op = instr_in.opword == cexu_pkg::OP_ILLEGAL;
  // Extension words never feed the illegal check
  wire logic illegal = instr_in.illegal || is_illegal_op ||
    (instr_in.is_stop && lowpwr_off) ||
    (instr_in.is_halt && !cfg_ff[cexu_pkg::CFG_BDM_BIT]);
  wire logic fetch_fault = instr_in.opword_faulted ||
    (instr_in.has_ext && instr_in.ext_faulted);
  wire logic odd_target = target_valid_in && target_addr_in[0];
  wire logic idx_fault = instr_in.has_ext && instr_in.indexed &&
                         bad_index(instr_in.ext1);
  // A mask of 7 still admits the non-maskable level
  wire logic irq_ok = !sampling_off_ff && irq_level_in != 3'h0 &&
    ((irq_level_in == cexu_pkg::LEVEL_NMI) ? !nmi_seen_ff
     : irq_level_in > sr_ff[10:8]);
  wire logic sync_wait = instr_in.valid && instr_in.is_nop &&
                         writes_pending_in;

  // --------------------------------------------------------------------
  // Event selection, highest priority first
  // --------------------------------------------------------------------
  always_comb
  begin
    ev = 1'b1;
    ev_reset = 1'b0;
    ev_irq = 1'b0;
    ev_fs = cexu_pkg::FS_NONE;
    ev_vec = cexu_pkg::VEC_ACCESS;
    ev_pc = instr_in.pc;
    ev_sp = ssp_ff;
    if (acc_rd)
    begin
      ev_fs = cexu_pkg::FS_READ;
      ev_reset = !cfg_ff[cexu_pkg::CFG_ARD_BIT];
    end
    else if (write_err_ff || acc_wr)
    begin
      // Imprecise: PC is whatever is at hand when it surfaces
      ev_fs = (acc_wr && acc_kind_in == cexu_pkg::CEXU_ACC_WPROT) ?
              cexu_pkg::FS_WPROT : cexu_pkg::FS_WRITE;
      ev_reset = !cfg_ff[cexu_pkg::CFG_ARD_BIT];
    end
    else if (instr_in.valid && (fetch_fault || fetch_err_ff))
    begin
      ev_fs = cexu_pkg::FS_FETCH;
      ev_reset = !cfg_ff[cexu_pkg::CFG_ARD_BIT];
    end
    else if (odd_target || (instr_in.valid && idx_fault))
    begin
      ev_vec = cexu_pkg::VEC_ADDR;
      ev_fs = cexu_pkg::FS_NONE;
      ev_reset = !cfg_ff[cexu_pkg::CFG_ARD_BIT];
      // Return fault: the frame covers the popped return address
      if (instr_in.is_rts)
        ev_sp = ssp_ff + 32'h0000_0004;
    end
    else if (instr_in.valid && illegal)
    begin
      // Line A and line F keep vectors of their own
      if (line == cexu_pkg::LINE_A)
        ev_vec = cexu_pkg::VEC_LINE_A;
      else if (line == cexu_pkg::LINE_F)
        ev_vec = cexu_pkg::VEC_LINE_F;
      else
        ev_vec = cexu_pkg::VEC_ILLEGAL;
      ev_reset = !cfg_ff[cexu_pkg::CFG_IRD_BIT] && !is_illegal_op;
    end
    else if (irq_ok && instr_in.valid && !sync_wait)
    begin
      // Taken at an instruction boundary; the frame PC is the next one
      ev_irq = 1'b1;
      ev_vec = irq_vector_in;
      ev_pc = instr_in.next_pc;
    end
    else
      ev = 1'b0;
  end

  // --------------------------------------------------------------------
  // APB slave, one wait state
  // --------------------------------------------------------------------
  // pready low is part of the take, so one request is served only once
  wire logic apb_acc = psel_in && penable_in && !pready_ff;
  wire logic apb_wr = apb_acc && pwrite_in;

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= apb_acc;
      pslverr_ff <= 1'b0;
      if (apb_acc && !pwrite_in)
      begin
        unique case (paddr_in)
          cexu_pkg::CFG_OFS: prdata_ff <= {27'h0, cfg_ff};
          cexu_pkg::STAT_OFS:
            prdata_ff <= {28'h0, sampling_off_ff, nmi_seen_ff,
                          write_err_ff, fetch_err_ff};
          cexu_pkg::FRAME0_OFS:
            prdata_ff <= {frame_ff.fmt, frame_ff.fs[3:2], frame_ff.vector,
                          frame_ff.fs[1:0], frame_ff.sr};
          cexu_pkg::FRAME1_OFS: prdata_ff <= frame_ff.pc;
          cexu_pkg::SSP_OFS: prdata_ff <= ssp_ff;
          cexu_pkg::SR_OFS: prdata_ff <= {16'h0, sr_ff};
          default:
          begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b1;
          end
        endcase
      end
      else if (apb_wr)
        pslverr_ff <= !(paddr_in == cexu_pkg::CFG_OFS ||
                        paddr_in == cexu_pkg::SSP_OFS ||
                        paddr_in == cexu_pkg::SR_OFS);
    end
  end

  // Configuration bits, cleared by reset
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      cfg_ff <= cexu_pkg::CFG_RST;
    else if (apb_wr && paddr_in == cexu_pkg::CFG_OFS)
      cfg_ff <= pwdata_in[4:0];
  end

  // --------------------------------------------------------------------
  // Stack pointer and status word
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ssp_ff <= 32'h0000_0000;
      sr_ff <= cexu_pkg::SR_RST;
    end
    else if (ev && !ev_reset)
    begin
      // Align down then push eight bytes
      ssp_ff <= {ev_sp[31:2], 2'b00} - cexu_pkg::FRAME_BYTES;
      // Supervisor on, trace off; interrupts also clear M and set the mask
      sr_ff[13] <= 1'b1;
      sr_ff[15] <= 1'b0;
      if (ev_irq)
      begin
        sr_ff[12] <= 1'b0;
        sr_ff[10:8] <= irq_level_in;
      end
    end
    else if (apb_wr && paddr_in == cexu_pkg::SSP_OFS)
      ssp_ff <= pwdata_in;
    else if (apb_wr && paddr_in == cexu_pkg::SR_OFS)
      sr_ff <= pwdata_in[15:0];
  end

  // --------------------------------------------------------------------
  // Deferred errors; a new fetch error wins over its own consumption
  // --------------------------------------------------------------------
  // A held fetch error is dropped only when no new one arrives with it
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      fetch_err_ff <= 1'b0;
    else if (acc_fe)
      fetch_err_ff <= 1'b1;
    else if (flow_change_in || (ev && !ev_irq))
      fetch_err_ff <= 1'b0;
  end

  // Kept only when a higher event wins; a reset request consumes it,
  // so that one write fault never asks for reset twice
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      write_err_ff <= 1'b0;
    else if (acc_wr && (acc_rd || !ev))
      write_err_ff <= 1'b1;
    else if (ev && !acc_rd)
      write_err_ff <= 1'b0;
  end

  // Level 7 edge memory and handler-first-instruction sampling block
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      nmi_seen_ff <= 1'b0;
      sampling_off_ff <= 1'b0;
    end
    else
    begin
      // Re-arm only after the level 7 request drops
      if (ev_irq && irq_level_in == cexu_pkg::LEVEL_NMI)
        nmi_seen_ff <= 1'b1;
      else if (irq_level_in != cexu_pkg::LEVEL_NMI)
        nmi_seen_ff <= 1'b0;
      if (ev && !ev_reset)
        sampling_off_ff <= 1'b1;
      else if (handler_first_done_in)
        sampling_off_ff <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Result outputs and frame
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      stall_ff <= 1'b0;
      exc_take_ff <= 1'b0;
      reset_req_ff <= 1'b0;
      abort_ff <= 1'b0;
      irq_ack_ff <= 1'b0;
      frame_ff <= '0;
      frame_addr_ff <= 32'h0000_0000;
    end
    else
    begin
      stall_ff <= sync_wait && !ev;
      exc_take_ff <= ev && !ev_reset;
      reset_req_ff <= ev && ev_reset;
      // Writes are imprecise and interrupts are no faults: no abort
      abort_ff <= ev && !ev_irq &&
                  !(!acc_rd && (write_err_ff || acc_wr));
      irq_ack_ff <= ev_irq;
      // A reset request leaves the frame of the last exception readable
      if (ev && !ev_reset)
      begin
        frame_ff.fmt <= cexu_pkg::FMT_BASE | {2'b00, ev_sp[1:0]};
        frame_ff.fs <= ev_fs;
        frame_ff.vector <= ev_vec;
        frame_ff.sr <= sr_ff;
        frame_ff.pc <= ev_pc;
        frame_addr_ff <= {ev_sp[31:2], 2'b00} - cexu_pkg::FRAME_BYTES;
      end
    end
  end

  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign stall_out = stall_ff;
  assign exc_take_out = exc_take_ff;
  assign reset_req_out = reset_req_ff;
  assign abort_out = abort_ff;
  assign frame_out = frame_ff;
  assign frame_addr_out = frame_addr_ff;
  assign irq_ack_out = irq_ack_ff;

endmodule

// >>> testbench/cexu_intc_model.sv
`timescale 1ns/100ps
module cexu_intc_model
(
  input wire logic [7:1] pend_in,
  output logic [2:0] level_out,
  output logic [7:0] vector_out,
  output logic [7:0] ack_query_out
);
  // ------------------------------------------------------------------
  // Fixed-priority request encoder
  // ------------------------------------------------------------------
  // Highest pending level wins; each level owns one fixed vector
  always_comb
  begin
    level_out = 3'h0;
    for (int i = 1; i < 8; i++)
      if (pend_in[i])
        level_out = 3'(i);
    // Idle vector is junk so a core that samples it without a request shows
    vector_out = 8'hff;
    if (level_out != 3'h0)
      vector_out = 8'h67 - 8'(level_out);
    // Software query sees masked requests too; zero when none pending
    ack_query_out = (level_out == 3'h0) ? 8'h00 : vector_out;
  end
endmodule

// >>> testbench/cexu_monitor.sv
`timescale 1ns/100ps
module cexu_monitor
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire cexu_pkg::cexu_instr_s instr_in,
  input wire logic acc_err_in,
  input wire cexu_pkg::cexu_acc_e acc_kind_in,
  input wire logic target_valid_in,
  input wire logic writes_pending_in,
  input wire logic [2:0] irq_level_in,
  input wire logic handler_first_done_in,
  input wire logic stall_out,
  input wire logic exc_take_out,
  input wire logic reset_req_out,
  input wire cexu_pkg::cexu_frame_s frame_out,
  input wire logic [31:0] frame_addr_out,
  input wire logic irq_ack_out
);
  // ------------------------------------------------------------------
  // Event checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  // Opword alone decides: no bus fault or jump competes that cycle
  sequence clean_s;
    instr_in.valid && !acc_err_in && !target_valid_in &&
    !instr_in.opword_faulted && !instr_in.indexed && instr_in.illegal;
  endsequence
  sequence rd_err_s;
    acc_err_in && acc_kind_in == cexu_pkg::CEXU_ACC_READ;
  endsequence
  chk_read_code: assert property (rd_err_s ##1 exc_take_out |->
    frame_out.fs == cexu_pkg::FS_READ) else $error("read fault code");
  chk_one_outcome: assert property (!(exc_take_out && reset_req_out))
    else $error("reset and exception together");
  chk_format_align: assert property (exc_take_out |->
    frame_out.fmt[3:2] == 2'h1 && frame_addr_out[1:0] == 2'h0)
    else $error("frame format or alignment");
  chk_status_zero: assert property (exc_take_out &&
    frame_out.vector > cexu_pkg::VEC_ADDR |-> frame_out.fs == 4'h0)
    else $error("status not zero");
  chk_illegal_op: assert property ((clean_s and
    instr_in.opword == cexu_pkg::OP_ILLEGAL) |=> exc_take_out)
    else $error("illegal opcode not taken");
  chk_line_a: assert property ((clean_s and
    instr_in.opword[15:12] == cexu_pkg::LINE_A) ##1 exc_take_out
    |-> frame_out.vector == cexu_pkg::VEC_LINE_A) else $error("line a");
  chk_nmi_once: assert property (irq_ack_out &&
    irq_level_in == 3'h7 && $past(irq_level_in) == 3'h7 |=> !irq_ack_out)
    else $error("level 7 taken twice");
  chk_sampling_off: assert property (exc_take_out &&
    !handler_first_done_in ##1 !handler_first_done_in |=> !irq_ack_out)
    else $error("interrupt taken before first handler op");
  chk_nop_stall: assert property (instr_in.valid &&
    instr_in.is_nop && writes_pending_in |=> stall_out)
    else $error("sync op did not stall");
endmodule

bind cexu_core_exception_unit cexu_monitor u_cexu_monitor (.*);

// >>> testbench/cexu_core_exception_unit_tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) \
  begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end

module cexu_core_exception_unit_tb_top;
  // ------------------------------------------------------------------
  // Stimulus, observation and clock
  // ------------------------------------------------------------------
  logic clk = 1'h0, rst_b = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic flow = 1'h0, tv = 1'h0, aerr = 1'h0, wpend = 1'h0, hdone = 1'h0;
  logic prdy, perr, stall, take, rreq, abrt, interrupt_acknowledge_query, se, ab;
  logic [7:0] pa = 8'h00;
  logic [7:0] ivec, ackq;
  logic [31:0] pwd = 32'h0, ta = 32'h0, prd, fa, q;
  logic [7:1] pend = 7'h00;
  logic [2:0] lvl;
  cexu_pkg::cexu_instr_s ins = '0;
  cexu_pkg::cexu_acc_e kind = cexu_pkg::CEXU_ACC_FETCH;
  cexu_pkg::cexu_frame_s fr;
  int bad_count = 0, samples_checked = 0, n = 0;
  // Free-running 25 MHz clock
  always #20 clk = ~clk;
  cexu_intc_model u_cexu_intc_model (.pend_in(pend), .level_out(lvl),
    .vector_out(ivec), .ack_query_out(ackq));
  cexu_core_exception_unit u_cexu_core_exception_unit (.ref_clk_in(clk),
    .rst_b_in(rst_b), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(perr), .instr_in(ins), .flow_change_in(flow),
    .target_valid_in(tv), .target_addr_in(ta), .acc_err_in(aerr),
    .acc_kind_in(kind), .writes_pending_in(wpend), .irq_level_in(lvl),
    .irq_vector_in(ivec), .handler_first_done_in(hdone),
    .stall_out(stall), .exc_take_out(take), .reset_req_out(rreq),
    .abort_out(abrt), .frame_out(fr), .frame_addr_out(fa),
    .irq_ack_out(interrupt_acknowledge_query));
  // ------------------------------------------------------------------
  // Shared drivers
  // ------------------------------------------------------------------
  // APB master: holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    @(posedge clk);
    // Only the watchdog ends a wait for pready
    while (prdy !== 1'h1)
      @(posedge clk);
    q = prd;
    se = perr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  // Caller sets event inputs; one edge later the pulses are judged
  task automatic ev(input string s, input logic t, r,
    input logic [3:0] f, input logic [7:0] v);
    @(posedge clk);
    aerr <= 1'h0;
    flow <= 1'h0;
    tv <= 1'h0;
    ins <= '0;
    @(negedge clk);
    ab = abrt;
    `CHK({s, " take"}, t, take)
    `CHK({s, " reset"}, r, rreq)
    if (t && f !== 4'hx)
      `CHK({s, " fs"}, f, fr.fs)
    if (t)
      `CHK({s, " vector"}, v, fr.vector)
    @(posedge clk);
  endtask
  task automatic put(input logic [15:0] o, input logic il);
    ins.valid <= 1'h1;
    ins.illegal <= il;
    ins.opword <= o;
  endtask
  // Acknowledge pulses are counted, since each lasts one cycle only
  task automatic acks(input int c);
    n = 0;
    repeat (c)
    begin
      @(negedge clk);
      n += int'(interrupt_acknowledge_query === 1'h1);
    end
    @(posedge clk);
  endtask
  task automatic first_done();
    hdone <= 1'h1;
    @(posedge clk);
    hdone <= 1'h0;
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_regs();
    `CHK("query idle", 8'h00, ackq)
    apb(1'h0, cexu_pkg::CFG_OFS, 32'h0);
    `CHK("cfg", 32'h0, q)
    apb(1'h0, cexu_pkg::SR_OFS, 32'h0);
    `CHK("sr", 32'h2700, q)
    apb(1'h0, 8'h40, 32'h0);
    `CHK("hole err", 1'h1, se)
    `CHK("hole data", 32'h0, q)
  endtask
  task automatic t_acc();
    aerr <= 1'h1;
    kind <= cexu_pkg::CEXU_ACC_READ;
    ev("rd rst", 1'h0, 1'h1, 4'hx, 8'h00);
    apb(1'h1, cexu_pkg::CFG_OFS, 32'h3);
    apb(1'h1, cexu_pkg::SSP_OFS, 32'h1001);
    aerr <= 1'h1;
    ev("rd", 1'h1, 1'h0, 4'hc, 8'h02);
    `CHK("rd abort", 1'h1, ab)
    `CHK("fmt", 4'h5, fr.fmt)
    `CHK("frame addr", 32'h0000_0ff8, fa)
    `CHK("frame sr", 16'h2700, fr.sr)
    kind <= cexu_pkg::CEXU_ACC_WRITE;
    aerr <= 1'h1;
    ev("wr", 1'h1, 1'h0, 4'h8, 8'h02);
    kind <= cexu_pkg::CEXU_ACC_WPROT;
    aerr <= 1'h1;
    ev("wprot", 1'h1, 1'h0, 4'h9, 8'h02);
  endtask
  task automatic t_fetch();
    kind <= cexu_pkg::CEXU_ACC_FETCH;
    aerr <= 1'h1;
    ev("fetch held", 1'h0, 1'h0, 4'hx, 8'h00);
    flow <= 1'h1;
    ev("flow", 1'h0, 1'h0, 4'hx, 8'h00);
    put(16'h0000, 1'h0);
    ev("after flow", 1'h0, 1'h0, 4'hx, 8'h00);
    put(16'h0000, 1'h0);
    ins.opword_faulted <= 1'h1;
    ins.pc <= 32'h0000_0300;
    ev("fetch", 1'h1, 1'h0, 4'h4, 8'h02);
    `CHK("fetch pc", 32'h0000_0300, fr.pc)
    `CHK("fetch abort", 1'h1, ab)
  endtask
  task automatic t_ill();
    logic [15:0] op [3] = '{16'h0123, 16'ha123, 16'hf123};
    logic [7:0] vec [3] = '{8'h04, 8'h0a, 8'h0b};
    for (int i = 0; i < 3; i++)
    begin
      put(op[i], 1'h1);
      ev("illegal", 1'h1, 1'h0, 4'h0, vec[i]);
    end
    apb(1'h1, cexu_pkg::CFG_OFS, 32'h1);
    put(16'h0123, 1'h1);
    ev("ill rst", 1'h0, 1'h1, 4'hx, 8'h00);
    put(16'h4afc, 1'h1);
    ev("ill op", 1'h1, 1'h0, 4'h0, 8'h04);
  endtask
  task automatic t_lp();
    logic [31:0] cf [5] = '{32'h03, 32'h07, 32'h0b, 32'h03, 32'h13};
    logic [4:0] il = 5'h09;
    for (int i = 0; i < 5; i++)
    begin
      apb(1'h1, cexu_pkg::CFG_OFS, cf[i]);
      put(16'h4000, 1'h0);
      ins.is_stop <= (i < 3);
      ins.is_halt <= (i > 2);
      ev("low power", il[i], 1'h0, 4'h0, 8'h04);
    end
  endtask
  task automatic t_addr();
    logic [15:0] ex [4] = '{16'h0000, 16'h0e00, 16'h0900, 16'h0800};
    tv <= 1'h1;
    ta <= 32'h0000_0101;
    ev("odd target", 1'h1, 1'h0, 4'hx, 8'h03);
    for (int i = 0; i < 4; i++)
    begin
      put(16'h2030, 1'h0);
      ins.indexed <= 1'h1;
      ins.has_ext <= 1'h1;
      ins.ext1 <= ex[i];
      ev("index", (i < 3), 1'h0, 4'hx, 8'h03);
    end
    apb(1'h1, cexu_pkg::CFG_OFS, 32'h2);
    tv <= 1'h1;
    ev("odd rst", 1'h0, 1'h1, 4'hx, 8'h00);
    apb(1'h1, cexu_pkg::CFG_OFS, 32'h3);
    apb(1'h1, cexu_pkg::SSP_OFS, 32'h2000);
    put(16'h4000, 1'h0);
    ins.is_rts <= 1'h1;
    tv <= 1'h1;
    ta <= 32'h0000_1001;
    ev("rts", 1'h1, 1'h0, 4'hx, 8'h03);
    `CHK("rts frame", 32'h0000_1ffc, fa)
  endtask
  // Sync op must wait for the write, then carry its error
  task automatic t_nop();
    wpend <= 1'h1;
    put(16'h4000, 1'h0);
    ins.is_nop <= 1'h1;
    @(posedge clk);
    @(negedge clk);
    `CHK("nop stall", 1'h1, stall)
    @(posedge clk);
    kind <= cexu_pkg::CEXU_ACC_WRITE;
    aerr <= 1'h1;
    wpend <= 1'h0;
    ev("nop wr", 1'h1, 1'h0, 4'h8, 8'h02);
    `CHK("stall end", 1'h0, stall)
  endtask
  task automatic t_irq();
    first_done();
    // Interrupts are sampled only while an instruction executes
    put(16'h0000, 1'h0);
    apb(1'h1, cexu_pkg::SR_OFS, 32'h2700);
    pend[5] <= 1'h1;
    acks(4);
    `CHK("masked", 32'h0, n)
    pend[7] <= 1'h1;
    acks(6);
    `CHK("nmi acks", 32'h1, n)
    `CHK("nmi vec", 8'h60, fr.vector)
    `CHK("nmi fs", 4'h0, fr.fs)
    pend <= 7'h04;
    apb(1'h1, cexu_pkg::SR_OFS, 32'h2000);
    `CHK("query", 8'h64, ackq)
    acks(4);
    `CHK("blocked", 32'h0, n)
    first_done();
    acks(4);
    `CHK("lvl3 acks", 32'h1, n)
    `CHK("lvl3 vec", 8'h64, fr.vector)
    pend <= 7'h00;
    ins <= '0;
  endtask
  // ------------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    t_regs();
    t_acc();
    t_fetch();
    t_ill();
    t_lp();
    t_addr();
    t_nop();
    t_irq();
    tally_and_finish();
  end
  // A hang costs a mismatch; the run needs under two hundred cycles
  initial
  begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
endmodule
